// >>> pkg/cg_params.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef CG_PARAMS_SVH
`define CG_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets and reset values
// ------------------------------------------------------------------
`define CG_OFS_CTRL_ONE  4'h0
`define CG_OFS_CTRL_TWO  4'h1
`define CG_RST_CTRL_ONE  8'h00
`define CG_RST_CTRL_TWO  8'h00

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define CG_HGO_BIT    7
`define CG_RANGE_BIT  6
`define CG_EXT_REF_SELECT_BIT   5
`define CG_MODE_MSB   4
`define CG_MODE_LSB   3
`define CG_KEEP_BIT   2
`define CG_CLOCK_LOSS_DETECT_DISABLE_BIT   1
`define CG_LOCK_LOSS_RESET_EN_BIT  7
`define CG_MFD_MSB    6
`define CG_MFD_LSB    4
`define CG_CLOCK_LOSS_RESET_EN_BIT  3
`define CG_RFD_MSB    2
`define CG_RFD_LSB    0

// ------------------------------------------------------------------
// Prescale values and field update timing
// ------------------------------------------------------------------
`define CG_P_LOW_RANGE   7'h40
`define CG_P_HIGH_RANGE  7'h01
`define CG_CLK_NS        10
`define CG_APPLY_NS      40
`define CG_APPLY_CYCLES  ((`CG_APPLY_NS + `CG_CLK_NS - 1) / `CG_CLK_NS)

`endif

// >>> pkg/cg_pkg.sv
// Types shared by the clock generator control logic
package cg_pkg;

  // ----------------------------------------------------------------
  // Clock modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CG_SELF = 2'b00,
    CG_FEI  = 2'b01,
    CG_FBE  = 2'b10,
    CG_FEE  = 2'b11
  } cg_mode_t;

  // ----------------------------------------------------------------
  // Loss requests toward the system
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lock_irq;
    logic lock_rst;
    logic clk_irq;
    logic clk_rst;
  } cg_req_t;

  // ----------------------------------------------------------------
  // Inputs arriving from the analog side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ext_ok;
    logic lock_lost;
    logic clock_lost;
    logic off_mode;
    logic enable;
  } cg_pins_t;

endpackage

// >>> rtl/cg_sync.sv
// Two-flop synchroniser for a bundle of level inputs
module cg_sync
#(
  parameter int WIDTH = 5
)
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two stages; only the second stage is read
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule

// >>> rtl/cg_ctrl.sv
// Control registers of the FLL based clock generator
//
// How it works
// R01 - Bit 7 picks low power or high amplitude
// R02 - Range bit sets prescale 64 or 1
// R03 - Range bit takes only first write
// R04 - Range matters only in external modes
// R05 - Reference select bit, first write only
// R06 - Mode field bits 4:3 select mode
// R07 - Bypass external waits for stable reference
// R08 - Off mode keeps mode field value
// R09 - Field writes ignored while previous pending
// R10 - First internal mode blocks external modes
// R11 - Bit 2 decides oscillator in off mode
// R12 - Clock loss detect disable bit
// R13 - Lock loss gives interrupt or reset
// R14 - Clock loss gives interrupt or reset
// R15 - Multiply field bits 6:4 sets N
// R16 - Divider field gives R of 2**code
// R17 - Software keeps loop clock below maximum
// R18 - Stable status follows external reference
// R19 - Status shows selected reference
// R20 - Lock loss status sticks until cleared
// R21 - Two eight bit read write registers
//
// The placing of the registers and strobed register access were decided locally.
`include "cg_params.svh"

module cg_ctrl
  import cg_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire cg_pins_t   pins_in,
  input  wire logic       irq_flag_clear,
  output logic            high_gain_select,
  output logic            osc_high_range,
  output logic      [6:0] loop_prescale,
  output cg_mode_t        clock_mode_active,
  output logic      [2:0] loop_multiply_field,
  output logic      [7:0] output_divide_factor,
  output logic            osc_enable,
  output logic            clock_loss_detect_en,
  output logic            ext_ref_stable,
  output logic            ref_select_status,
  output logic            lock_loss_status,
  output cg_req_t         loss_req
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [3:0] APPLY = 4'(`CG_APPLY_CYCLES);

  cg_pins_t   pins_s;
  logic [7:0] one_reg, one_next, two_reg, two_next;
  logic       seen_reg, seen_next, block_reg, block_next;
  cg_mode_t   mode_reg, mode_next;
  logic [2:0] mfd_reg, mfd_next, rfd_reg, rfd_next;
  logic [3:0] cnt_reg [3];
  logic [3:0] cnt_next [3];
  logic       lls_reg, lls_next, lcs_reg, lcs_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       wr_one, wr_two, mode_ok, ext_mode;
  cg_mode_t   mode_req;

  // Output flops
  logic       hgo_reg, range_reg, osc_reg, lcd_reg, ers_reg, rss_reg;
  logic [6:0] pre_reg, pre_next;
  logic [7:0] div_reg;
  cg_req_t    req_reg, req_next;
  logic       osc_next, lock_loss_reset_en, clock_loss_reset_en;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  cg_sync #(.WIDTH($bits(cg_pins_t))) u_sync
  (
    .clock (clock),
    .srst  (srst),
    .din   (pins_in),
    .dout  (pins_s)
  );

  // ----------------------------------------------------------------
  // Register file and field update state
  // ----------------------------------------------------------------
  assign wr_one   = reg_wr && reg_addr == `CG_OFS_CTRL_ONE;
  assign wr_two   = reg_wr && reg_addr == `CG_OFS_CTRL_TWO;
  assign mode_req = cg_mode_t'(one_reg[`CG_MODE_MSB:`CG_MODE_LSB]);
  assign lock_loss_reset_en    = two_reg[`CG_LOCK_LOSS_RESET_EN_BIT];
  assign clock_loss_reset_en    = two_reg[`CG_CLOCK_LOSS_RESET_EN_BIT];
  // External reference modes are 1X
  assign ext_mode = mode_req[1];
  // Mode write accepted when idle and not blocked
  assign mode_ok  = cnt_reg[0] == 4'h0
                    && !(block_reg && reg_wdata[`CG_MODE_MSB]); // [R09][R10]

  // Next values of control registers, pending counts and status
  always_comb
  begin
    one_next   = one_reg;
    two_next   = two_reg;
    seen_next  = seen_reg;
    block_next = block_reg;
    mode_next  = mode_reg;
    mfd_next   = mfd_reg;
    rfd_next   = rfd_reg;
    for (int i = 0; i < 3; i++)
      cnt_next[i] = cnt_reg[i];
    if (wr_one)
    begin
      one_next[`CG_HGO_BIT]  = reg_wdata[`CG_HGO_BIT];               // [R01]
      one_next[`CG_KEEP_BIT] = reg_wdata[`CG_KEEP_BIT];              // [R11]
      one_next[`CG_CLOCK_LOSS_DETECT_DISABLE_BIT] = reg_wdata[`CG_CLOCK_LOSS_DETECT_DISABLE_BIT];              // [R12]
      if (!seen_reg)
      begin
        one_next[`CG_RANGE_BIT] = reg_wdata[`CG_RANGE_BIT];          // [R03]
        one_next[`CG_EXT_REF_SELECT_BIT]  = reg_wdata[`CG_EXT_REF_SELECT_BIT];           // [R05]
        block_next = !reg_wdata[`CG_MODE_MSB];                       // [R10]
      end
      seen_next = 1'b1;
      if (mode_ok)
      begin
        one_next[`CG_MODE_MSB:`CG_MODE_LSB] =
          reg_wdata[`CG_MODE_MSB:`CG_MODE_LSB];                      // [R06]
        cnt_next[0] = APPLY;
      end
    end
    if (wr_two)
    begin
      two_next[`CG_LOCK_LOSS_RESET_EN_BIT] = reg_wdata[`CG_LOCK_LOSS_RESET_EN_BIT];            // [R13]
      two_next[`CG_CLOCK_LOSS_RESET_EN_BIT] = reg_wdata[`CG_CLOCK_LOSS_RESET_EN_BIT];            // [R14]
      if (cnt_reg[1] == 4'h0)
      begin
        two_next[`CG_MFD_MSB:`CG_MFD_LSB] =
          reg_wdata[`CG_MFD_MSB:`CG_MFD_LSB];                        // [R09]
        cnt_next[1] = APPLY;
      end
      if (cnt_reg[2] == 4'h0)
      begin
        two_next[`CG_RFD_MSB:`CG_RFD_LSB] =
          reg_wdata[`CG_RFD_MSB:`CG_RFD_LSB];                        // [R09]
        cnt_next[2] = APPLY;
      end
    end
    // Count down; bypass external holds until reference is stable
    if (cnt_reg[0] > 4'h1)
      cnt_next[0] = cnt_reg[0] - 4'h1;
    else if (cnt_reg[0] == 4'h1
             && (mode_req != CG_FBE || pins_s.ext_ok))               // [R07]
    begin
      mode_next   = mode_req;
      cnt_next[0] = 4'h0;
    end
    if (cnt_reg[1] > 4'h1)
      cnt_next[1] = cnt_reg[1] - 4'h1;
    else if (cnt_reg[1] == 4'h1)
    begin
      mfd_next    = two_reg[`CG_MFD_MSB:`CG_MFD_LSB];                // [R15]
      cnt_next[1] = 4'h0;
    end
    if (cnt_reg[2] > 4'h1)
      cnt_next[2] = cnt_reg[2] - 4'h1;
    else if (cnt_reg[2] == 4'h1)
    begin
      rfd_next    = two_reg[`CG_RFD_MSB:`CG_RFD_LSB];                // [R16]
      cnt_next[2] = 4'h0;
    end
    one_next[0] = 1'b0;
    // Sticky loss flags; a new event beats the clear
    lls_next = pins_s.lock_lost | (lls_reg & !irq_flag_clear);       // [R20]
    lcs_next = (pins_s.clock_lost & !one_reg[`CG_CLOCK_LOSS_DETECT_DISABLE_BIT])
               | (lcs_reg & !irq_flag_clear);                        // [R12]
    // Registered read answer, unmapped reads as zero
    rdata_next = 8'h00;
    if (reg_rd && reg_addr == `CG_OFS_CTRL_ONE)
      rdata_next = one_reg;                                          // [R21]
    else if (reg_rd && reg_addr == `CG_OFS_CTRL_TWO)
      rdata_next = two_reg;                                          // [R21]
  end

  // Registers; off mode never touches the mode field
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      one_reg   <= `CG_RST_CTRL_ONE;
      two_reg   <= `CG_RST_CTRL_TWO;
      seen_reg  <= 1'b0;
      block_reg <= 1'b0;
      mode_reg  <= CG_SELF;
      mfd_reg   <= 3'h0;
      rfd_reg   <= 3'h0;
      for (int i = 0; i < 3; i++)
        cnt_reg[i] <= 4'h0;
      lls_reg   <= 1'b0;
      lcs_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      one_reg   <= one_next;                                         // [R08]
      two_reg   <= two_next;
      seen_reg  <= seen_next;
      block_reg <= block_next;
      mode_reg  <= mode_next;
      mfd_reg   <= mfd_next;
      rfd_reg   <= rfd_next;
      for (int i = 0; i < 3; i++)
        cnt_reg[i] <= cnt_next[i];
      lls_reg   <= lls_next;
      lcs_reg   <= lcs_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Derived outputs
  // ----------------------------------------------------------------
  // Prescale, oscillator enable and loss requests
  always_comb
  begin
    pre_next = `CG_P_LOW_RANGE;
    if ((mode_reg == CG_FBE || mode_reg == CG_FEE)
        && one_reg[`CG_RANGE_BIT])                                   // [R04]
      pre_next = `CG_P_HIGH_RANGE;                                   // [R02]
    if (!pins_s.off_mode)
      osc_next = mode_reg[1] && one_reg[`CG_EXT_REF_SELECT_BIT];
    else if (one_reg[`CG_KEEP_BIT])
      osc_next = ext_mode && one_reg[`CG_EXT_REF_SELECT_BIT];                  // [R11]
    else
      osc_next = pins_s.enable && mode_req == CG_FBE
                 && one_reg[`CG_EXT_REF_SELECT_BIT];                           // [R11]
    req_next.lock_irq = lls_reg && !lock_loss_reset_en;                           // [R13]
    req_next.lock_rst = lls_reg && lock_loss_reset_en;                            // [R13]
    req_next.clk_irq  = lcs_reg && !clock_loss_reset_en;                           // [R14]
    req_next.clk_rst  = lcs_reg && clock_loss_reset_en;                            // [R14]
  end

  // Output flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hgo_reg   <= 1'b0;
      range_reg <= 1'b0;
      pre_reg   <= `CG_P_LOW_RANGE;
      div_reg   <= 8'h01;
      osc_reg   <= 1'b0;
      lcd_reg   <= 1'b0;
      ers_reg   <= 1'b0;
      rss_reg   <= 1'b0;
      req_reg   <= '0;
    end
    else
    begin
      hgo_reg   <= one_reg[`CG_HGO_BIT];                             // [R01]
      range_reg <= one_reg[`CG_RANGE_BIT] && mode_reg[1];            // [R04]
      pre_reg   <= pre_next;
      div_reg   <= 8'h01 << rfd_reg;                                 // [R16]
      osc_reg   <= osc_next;
      lcd_reg   <= !one_reg[`CG_CLOCK_LOSS_DETECT_DISABLE_BIT];                           // [R12]
      ers_reg   <= pins_s.ext_ok;                                    // [R18]
      rss_reg   <= one_reg[`CG_EXT_REF_SELECT_BIT];                            // [R19]
      req_reg   <= req_next;
    end
  end

  // Multiply code is applied as written; software keeps N low [R17]
  assign reg_rdata            = rdata_reg;
  assign high_gain_select     = hgo_reg;
  assign osc_high_range       = range_reg;
  assign loop_prescale        = pre_reg;
  assign clock_mode_active    = mode_reg;
  assign loop_multiply_field  = mfd_reg;
  assign output_divide_factor = div_reg;
  assign osc_enable           = osc_reg;
  assign clock_loss_detect_en = lcd_reg;
  assign ext_ref_stable       = ers_reg;
  assign ref_select_status    = rss_reg;
  assign lock_loss_status     = lls_reg;
  assign loss_req             = req_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_late_one_wr;
    seen_reg && wr_one;
  endsequence

  sequence s_mode_busy_wr;
    wr_one && cnt_reg[0] != 4'h0;
  endsequence

  a_range_once: assert property (s_late_one_wr |=> // [R03]
    one_reg[`CG_RANGE_BIT] == $past(one_reg[`CG_RANGE_BIT]))
    else $error("range bit changed after first write");

  a_ext_ref_select_once: assert property (s_late_one_wr |=> // [R05]
    one_reg[`CG_EXT_REF_SELECT_BIT] == $past(one_reg[`CG_EXT_REF_SELECT_BIT]))
    else $error("reference select changed after first write");

  a_mode_pend: assert property (s_mode_busy_wr |=> // [R09]
    one_reg[`CG_MODE_MSB:`CG_MODE_LSB]
      == $past(one_reg[`CG_MODE_MSB:`CG_MODE_LSB]))
    else $error("mode field written while pending");

  a_ext_blocked: assert property (block_reg |-> // [R10]
    !one_reg[`CG_MODE_MSB] && !mode_reg[1])
    else $error("external mode reached after internal first write");

  a_bypass_wait: assert property ( // [R07]
    mode_reg == CG_FBE && $past(mode_reg) != CG_FBE |->
      $past(pins_s.ext_ok))
    else $error("bypass external entered without stable reference");

  a_mode_apply: assert property ( // [R06]
    wr_one && mode_ok && reg_wdata[`CG_MODE_MSB:`CG_MODE_LSB] != 2'b10
    ##1 !wr_one [*4] |=> mode_reg == $past(mode_req))
    else $error("mode not applied after update time");

  a_lock_req: assert property (lls_reg |=> // [R13]
    loss_req.lock_irq == !$past(lock_loss_reset_en) && loss_req.lock_rst == $past(lock_loss_reset_en))
    else $error("lock loss request type wrong");

  a_clock_req: assert property (lcs_reg |=> // [R14]
    loss_req.clk_rst == $past(clock_loss_reset_en) && loss_req.clk_irq != $past(clock_loss_reset_en))
    else $error("clock loss request type wrong");

  a_lls_hold: assert property (lls_reg && !irq_flag_clear |=> // [R20]
    lls_reg [*2] or (lls_reg ##1 $past(irq_flag_clear)))
    else $error("lock loss status dropped without clear");

  a_div_factor: assert property (##1 // [R16]
    output_divide_factor == (8'h01 << $past(rfd_reg)))
    else $error("divide factor mismatch");

  a_prescale: assert property (!mode_reg[1] |=> // [R04]
    loop_prescale == `CG_P_LOW_RANGE)
    else $error("range affected internal mode prescale");

  a_rd_answer: assert property ( // [R21]
    reg_rd && reg_addr == `CG_OFS_CTRL_TWO |=>
      reg_rdata == $past(two_reg))
    else $error("read data of second register wrong");

endmodule

// >>> sim/clock_gen_control_regs_test.sv
// Self-checking bench for the clock generator control registers
`include "cg_params.svh"

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  error_cnt++; $display("ERROR %0t: got %h exp %h", $time, got, exp); end end

module clock_gen_control_regs_test
  import cg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  cg_pins_t   pins_in = '0;
  logic       irq_flag_clear = 1'b0;
  logic       high_gain_select;
  logic       osc_high_range;
  logic [6:0] loop_prescale;
  cg_mode_t   clock_mode_active;
  logic [2:0] loop_multiply_field;
  logic [7:0] output_divide_factor;
  logic       osc_enable;
  logic       clock_loss_detect_en;
  logic       ext_ref_stable;
  logic       ref_select_status;
  logic       lock_loss_status;
  cg_req_t    loss_req;
  int         error_cnt = 0;
  int         comparisons = 0;
  logic [7:0] rd_val;

  cg_ctrl dut_u (
    .clock                (clock),
    .srst                 (srst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .pins_in              (pins_in),
    .irq_flag_clear       (irq_flag_clear),
    .high_gain_select     (high_gain_select),
    .osc_high_range       (osc_high_range),
    .loop_prescale        (loop_prescale),
    .clock_mode_active    (clock_mode_active),
    .loop_multiply_field  (loop_multiply_field),
    .output_divide_factor (output_divide_factor),
    .osc_enable           (osc_enable),
    .clock_loss_detect_en (clock_loss_detect_en),
    .ext_ref_stable       (ext_ref_stable),
    .ref_select_status    (ref_select_status),
    .lock_loss_status     (lock_loss_status),
    .loss_req             (loss_req)
  );

  // 100 MHz clock
  always #5 clock = ~clock;

  // ------------------------------------------------------------------
  // Bus and timing helpers
  // ------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic do_reset(input int n);
    @(posedge clock);
    srst <= 1'b1;
    repeat (n) @(posedge clock);
    srst <= 1'b0;
    tick(1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Bounded wait for an applied mode; gives up into the closing report
  task automatic wait_mode(input cg_mode_t m);
    int i;
    for (i = 0; i < 30 && clock_mode_active !== m; i++)
      tick(1);
    if (clock_mode_active !== m)
    begin
      error_cnt++;
      $display("ERROR %0t: mode never applied", $time);
      end_of_test();
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_values();
    `CHECK(loop_prescale, `CG_P_LOW_RANGE);
    `CHECK(output_divide_factor, 8'h01);
    `CHECK(clock_mode_active, CG_SELF);
    rd(`CG_OFS_CTRL_ONE, rd_val);
    `CHECK(rd_val, `CG_RST_CTRL_ONE);
    rd(`CG_OFS_CTRL_TWO, rd_val);
    `CHECK(rd_val, `CG_RST_CTRL_TWO);
    wr(4'h7, 8'hff);
    rd(4'h7, rd_val);
    `CHECK(rd_val, 8'h00);
    $display("Test reset values done");
  endtask

  task automatic test_ctrl_one_write_once();
    wr(`CG_OFS_CTRL_ONE, 8'hf9);
    rd(`CG_OFS_CTRL_ONE, rd_val);
    `CHECK(rd_val, 8'hf8);
    tick(8);
    `CHECK(clock_mode_active, CG_FEE);
    `CHECK(high_gain_select, 1'b1);
    `CHECK(loop_prescale, `CG_P_HIGH_RANGE);
    `CHECK(osc_high_range, 1'b1);
    `CHECK(ref_select_status, 1'b1);
    `CHECK(clock_loss_detect_en, 1'b1);
    `CHECK(osc_enable, 1'b1);
    wr(`CG_OFS_CTRL_ONE, 8'h02);
    rd(`CG_OFS_CTRL_ONE, rd_val);
    `CHECK(rd_val, 8'h62);
    tick(8);
    `CHECK(clock_mode_active, CG_SELF);
    `CHECK(loop_prescale, `CG_P_LOW_RANGE);
    `CHECK(osc_high_range, 1'b0);
    `CHECK(high_gain_select, 1'b0);
    `CHECK(clock_loss_detect_en, 1'b0);
    `CHECK(ref_select_status, 1'b1);
    $display("Test write once done");
  endtask

  task automatic test_pending_and_divide();
    int c;
    wr(`CG_OFS_CTRL_TWO, 8'h31);
    wr(`CG_OFS_CTRL_TWO, 8'hcf);
    rd(`CG_OFS_CTRL_TWO, rd_val);
    `CHECK(rd_val, 8'hb9);
    tick(8);
    `CHECK(loop_multiply_field, 3'h3);
    `CHECK(output_divide_factor, 8'h02);
    for (c = 0; c < 8; c++)
    begin
      // Multiply code kept at its lowest value
      wr(`CG_OFS_CTRL_TWO, {5'h00, c[2:0]});
      tick(8);
      `CHECK(output_divide_factor, 8'h01 << c);
      `CHECK(loop_multiply_field, 3'h0);
    end
    $display("Test pending and divide done");
  endtask

  task automatic test_loss_requests();
    wr(`CG_OFS_CTRL_TWO, 8'h00);
    tick(6);
    `CHECK(loss_req, 4'h0);
    pins_in.lock_lost <= 1'b1;
    tick(6);
    `CHECK(lock_loss_status, 1'b1);
    `CHECK(loss_req, 4'h8);
    pins_in.lock_lost <= 1'b0;
    tick(6);
    `CHECK(lock_loss_status, 1'b1);
    irq_flag_clear <= 1'b1;
    tick(1);
    irq_flag_clear <= 1'b0;
    tick(3);
    `CHECK(lock_loss_status, 1'b0);
    `CHECK(loss_req, 4'h0);
    wr(`CG_OFS_CTRL_TWO, 8'h80);
    pins_in.lock_lost <= 1'b1;
    tick(6);
    `CHECK(loss_req, 4'h4);
    pins_in.lock_lost <= 1'b0;
    pins_in.clock_lost <= 1'b1;
    tick(6);
    irq_flag_clear <= 1'b1;
    tick(1);
    irq_flag_clear <= 1'b0;
    tick(3);
    `CHECK(loss_req, 4'h0);
    wr(`CG_OFS_CTRL_ONE, 8'h60);
    tick(6);
    `CHECK(loss_req, 4'h2);
    wr(`CG_OFS_CTRL_TWO, 8'h08);
    tick(4);
    `CHECK(loss_req, 4'h1);
    pins_in.clock_lost <= 1'b0;
    $display("Test loss requests done");
  endtask

  task automatic test_internal_blocks_external();
    do_reset(3);
    wr(`CG_OFS_CTRL_ONE, 8'h08);
    wait_mode(CG_FEI);
    tick(6);
    wr(`CG_OFS_CTRL_ONE, 8'h18);
    rd(`CG_OFS_CTRL_ONE, rd_val);
    `CHECK(rd_val, 8'h08);
    tick(8);
    `CHECK(clock_mode_active, CG_FEI);
    $display("Test external block done");
  endtask

  task automatic test_bypass_and_off_mode();
    do_reset(3);
    wr(`CG_OFS_CTRL_ONE, 8'h30);
    tick(10);
    `CHECK(ext_ref_stable, 1'b0);
    `CHECK(clock_mode_active, CG_SELF);
    pins_in.ext_ok <= 1'b1;
    tick(4);
    `CHECK(ext_ref_stable, 1'b1);
    wait_mode(CG_FBE);
    tick(2);
    `CHECK(osc_enable, 1'b1);
    pins_in.off_mode <= 1'b1;
    tick(5);
    `CHECK(osc_enable, 1'b0);
    rd(`CG_OFS_CTRL_ONE, rd_val);
    `CHECK(rd_val, 8'h30);
    pins_in.enable <= 1'b1;
    tick(5);
    `CHECK(osc_enable, 1'b1);
    pins_in.enable <= 1'b0;
    wr(`CG_OFS_CTRL_ONE, 8'h3c);
    tick(10);
    `CHECK(osc_enable, 1'b1);
    pins_in.off_mode <= 1'b0;
    $display("Test bypass and off mode done");
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    tick(1);
    test_reset_values();
    test_ctrl_one_write_once();
    test_pending_and_divide();
    test_loss_requests();
    test_internal_blocks_external();
    test_bypass_and_off_mode();
    end_of_test();
  end

endmodule
